// [frame_fifo.sv]
// file: frame fifo shared by transmit and receive paths
`timescale 1ns/1ps
module frame_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   // drain side
   input wire logic pop,
   output logic [WIDTH-1:0] pop_data,
   // levels
   output logic empty,
   output logic full,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   // pointer arithmetic needs a power of two depth
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : bad_depth
         $error("frame_fifo depth must be a power of two");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic do_push;
   logic do_pop;

   // pushes into a full fifo and pops of an empty one are dropped
   assign do_push = push && !full;
   assign do_pop = pop && !empty;
   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign count = wr_q - rd_q;
   assign pop_data = mem_q[rd_q[AW-1:0]];

   // pointers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (do_push) wr_q <= wr_q + 1'b1;
         if (do_pop) rd_q <= rd_q + 1'b1;
      end
   end

   // storage has no reset, only the pointers matter
   always_ff @(posedge clk) begin
      if (do_push) mem_q[wr_q[AW-1:0]] <= push_data;
   end

endmodule : frame_fifo

// [serial_engine.sv]
// file: master shift engine for one serial frame at a time
`timescale 1ns/1ps
module serial_engine (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration
   input wire logic run_en,
   input wire logic loop_back,
   input wire ssp_pkg::serial_cfg_t cfg,
   // transmit fifo head
   input wire logic tx_avail,
   input wire logic [15:0] tx_data,
   output logic tx_pop,
   // receive result
   output logic rx_push,
   output logic [15:0] rx_data,
   output logic busy,
   // pins
   output logic sck_q,
   output logic mosi_q,
   output logic ssel_q,
   input wire logic miso
);
   ssp_pkg::eng_state_t state_q;
   logic [6:0] pre_q;
   logic [7:0] rate_q;
   logic [4:0] edge_q;
   logic [15:0] tx_sh_q;
   logic [15:0] rx_sh_q;
   logic [6:0] half_div;
   logic tick;
   logic sample_edge;
   logic shift_edge;
   logic last_edge;
   logic in_bit;
   logic [4:0] last_idx;

   // half bit = divisor/2 * (rate+1) clocks, divisor of 0 or 1 acts as 2
   assign half_div = (cfg.prescale_divisor[7:1] == 7'h00) ? 7'h01
                     : cfg.prescale_divisor[7:1];
   assign tick = (state_q == ssp_pkg::ENG_RUN) && (pre_q == half_div - 7'h01)
                 && (rate_q == cfg.bit_rate_divider);
   assign sample_edge = tick && (edge_q[0] == cfg.capture_edge_phase);
   assign shift_edge = tick && (edge_q[0] != cfg.capture_edge_phase)
                       && !(cfg.capture_edge_phase && edge_q == 5'h00);
   assign last_idx = {cfg.frame_size_select, 1'b1};
   assign last_edge = tick && (edge_q == last_idx);
   assign in_bit = loop_back ? mosi_q : miso;
   assign busy = (state_q == ssp_pkg::ENG_RUN);
   assign tx_pop = (state_q == ssp_pkg::ENG_IDLE) && run_en && tx_avail;
   assign rx_data = rx_sh_q;

   // frame sequencing and rate dividers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ssp_pkg::ENG_IDLE;
         pre_q <= 7'h00;
         rate_q <= 8'h00;
         edge_q <= 5'h00;
         rx_push <= 1'b0;
      end else begin
         rx_push <= last_edge;
         case (state_q)
            ssp_pkg::ENG_IDLE: begin
               pre_q <= 7'h00;
               rate_q <= 8'h00;
               edge_q <= 5'h00;
               if (tx_pop) state_q <= ssp_pkg::ENG_RUN;
            end
            ssp_pkg::ENG_RUN: begin
               if (pre_q == half_div - 7'h01) begin
                  pre_q <= 7'h00;
                  rate_q <= tick ? 8'h00 : rate_q + 8'h01;
               end else begin
                  pre_q <= pre_q + 7'h01;
               end
               if (tick) edge_q <= edge_q + 5'h01;
               if (last_edge) state_q <= ssp_pkg::ENG_IDLE;
            end
            default: state_q <= ssp_pkg::ENG_IDLE;
         endcase
      end
   end

   // shifters and pins; only the low frame bits are sent
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_q <= 16'h0000;
         rx_sh_q <= 16'h0000;
         sck_q <= 1'b0;
         mosi_q <= 1'b0;
         ssel_q <= 1'b0;
      end else begin
         if (tx_pop) begin
            tx_sh_q <= tx_data;
            rx_sh_q <= 16'h0000;
            mosi_q <= tx_data[cfg.frame_size_select];
         end
         if (shift_edge) begin
            tx_sh_q <= {tx_sh_q[14:0], 1'b0};
            mosi_q <= tx_sh_q[cfg.frame_size_select - 4'h1];
         end
         if (sample_edge) rx_sh_q <= {rx_sh_q[14:0], in_bit};
         // idle level of the clock, plain high-true otherwise
         if (cfg.frame_format != ssp_pkg::FMT_SPI) sck_q <= tick ? !sck_q : 1'b0;
         else if (!busy) sck_q <= cfg.clock_idle_level;
         else if (tick) sck_q <= !sck_q;
         // select polarity follows the frame format
         if (cfg.frame_format == ssp_pkg::FMT_SYNC) ssel_q <= tx_pop;
         else ssel_q <= !(tx_pop || (busy && !last_edge));
      end
   end

endmodule : serial_engine

// [ssp_peer.sv]
// partner: serial peripheral on the far side of the port
`timescale 1ns/1ps
module ssp_peer #(
   parameter logic [15:0] REPLY = 16'hC3A5
) (
   // serial pins
   input wire logic sck,
   input wire logic mosi,
   input wire logic ssel,
   output logic miso,
   // frame length and captured frame
   input wire logic [4:0] nbits,
   output logic [15:0] got,
   output logic [4:0] cnt
);
   int idx;
   initial begin
      miso = 1'b0;
      got = 16'h0000;
      cnt = 5'h00;
   end
   // msb goes out before the first edge
   always @(negedge ssel) begin
      got = 16'h0000;
      cnt = 5'h00;
      idx = int'(nbits) - 1;
      miso = REPLY[idx];
   end
   always @(posedge sck) begin
      if (!ssel) begin
         got = {got[14:0], mosi};
         cnt = cnt + 5'h01;
      end
   end
   // released line flips so a stale bit cannot pass for data
   always @(negedge sck or posedge ssel) begin
      idx = idx - 1;
      if (ssel || idx < 0) miso = ~miso;
      else miso = REPLY[idx];
   end
endmodule : ssp_peer

// [ssp_pkg.sv]
// package: register map, field layout and carriers of the serial port
package ssp_pkg;

   // ****************************************************************
   // instance bases and register offsets
   // ****************************************************************
   localparam logic [31:0] BASE_FIRST = 32'h4004_0000;
   localparam logic [31:0] BASE_SECOND = 32'h4005_8000;
   localparam logic [11:0] OFF_CTRL0 = 12'h000;
   localparam logic [11:0] OFF_CTRL1 = 12'h004;
   localparam logic [11:0] OFF_DATA = 12'h008;
   localparam logic [11:0] OFF_STAT = 12'h00C;
   localparam logic [11:0] OFF_PRESC = 12'h010;
   localparam logic [11:0] OFF_MASK = 12'h014;
   localparam logic [11:0] OFF_RAW = 12'h018;
   localparam logic [11:0] OFF_MSKD = 12'h01C;
   localparam logic [11:0] OFF_CLR = 12'h020;

   // ****************************************************************
   // reset values of the implemented bits
   // ****************************************************************
   localparam logic [15:0] CTRL0_RST = 16'h0000;
   localparam logic [2:0] CTRL1_RST = 3'h0;
   localparam logic [7:0] PRESC_RST = 8'h00;
   localparam logic [3:0] MASK_RST = 4'h0;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int C1_LOOP = 0;
   localparam int C1_EN = 1;
   localparam int C1_SLAVE = 2;
   localparam int ST_TX_EMPTY = 0;
   localparam int ST_TX_NFULL = 1;
   localparam int ST_RX_NEMPTY = 2;
   localparam int ST_RX_FULL = 3;
   localparam int ST_BUSY = 4;
   localparam int IRQ_OVERRUN = 0;
   localparam int IRQ_TIMEOUT = 1;
   localparam int IRQ_RX_HALF = 2;
   localparam int IRQ_TX_HALF = 3;

   // ****************************************************************
   // sizes and counts
   // ****************************************************************
   localparam int FRAME_W = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int TIMEOUT_CYC = 64;

   // frame format codes, code 3 is not supported
   typedef enum logic [1:0] {
      FMT_SPI = 2'h0,
      FMT_SYNC = 2'h1,
      FMT_CMD = 2'h2
   } fmt_t;

   typedef enum logic [0:0] {
      ENG_IDLE = 1'h0,
      ENG_RUN = 1'h1
   } eng_state_t;

   // low 16 bits mirror control_zero, prescale divisor on top
   typedef struct packed {
      logic [7:0] prescale_divisor;
      logic [7:0] bit_rate_divider;
      logic capture_edge_phase;
      logic clock_idle_level;
      logic [1:0] frame_format;
      logic [3:0] frame_size_select;
   } serial_cfg_t;

endpackage : ssp_pkg

// [ssp_port_checker.sv]
// checker: bus timing, refusals and pin relations of the port
`timescale 1ns/1ps
module ssp_port_checker #(
   parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
   // clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic mosi_o,
   input wire logic mosi_oe,
   input wire logic ssel_o,
   input wire logic ssel_oe,
   input wire logic miso_i,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire rd_done = pready && !pwrite && !pslverr;
   wire setup = psel && !penable;
   wire wr_done = psel && penable && pready && pwrite;
   setup_answer_a: assert property (setup |=> pready)
      else $error("no answer after setup");
   ready_access_a: assert property (pready |-> penable && $past(setup))
      else $error("answer outside access");
   ready_single_a: assert property (pready |=> !pready)
      else $error("answer held too long");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without answer");
   foreign_base_a: assert property (setup && paddr[31:12] !=
      BASE_ADDR[31:12] |=> pslverr) else $error("foreign base taken");
   unmapped_a: assert property (setup && paddr[11:0] > 12'h020 |=>
      pslverr) else $error("unmapped offset taken");
   clear_read_a: assert property (rd_done && paddr[11:0] ==
      ssp_pkg::OFF_CLR |-> prdata == 32'h0) else $error("clear reg read");
   data_width_a: assert property (rd_done && paddr[11:0] ==
      ssp_pkg::OFF_DATA |-> prdata[31:16] == 16'h0) else $error("rx wide");
   masked_irq_a: assert property (rd_done && paddr[11:0] ==
      ssp_pkg::OFF_MSKD && prdata[3:0] != 4'h0 |-> ##[0:2] irq)
      else $error("irq missing");
   oe_tied_a: assert property (sck_oe == mosi_oe && sck_oe == ssel_oe)
      else $error("enables differ");
   // a control write may move the idle level two edges after it lands
   idle_clock_a: assert property (ssel_o && $past(ssel_o) &&
      !$past(wr_done, 2) |-> $stable(sck_o))
      else $error("clock moves while idle");
endmodule : ssp_port_checker
bind sync_serial_port_regs ssp_port_checker #(.BASE_ADDR(BASE_ADDR))
   ssp_port_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_o(sck_o),
   .sck_oe(sck_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .ssel_o(ssel_o),
   .ssel_oe(ssel_oe), .miso_i(miso_i), .irq(irq));

// [sync_serial_port_regs.sv]
// file: register interface and top of the synchronous serial port
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module sync_serial_port_regs #(
   parameter logic [31:0] BASE_ADDR = ssp_pkg::BASE_FIRST
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial pins
   output logic sck_o,
   output logic sck_oe,
   output logic mosi_o,
   output logic mosi_oe,
   output logic ssel_o,
   output logic ssel_oe,
   input wire logic miso_i,
   // interrupt
   output logic irq
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   // only the two documented bases are served
   generate
      if (BASE_ADDR != ssp_pkg::BASE_FIRST &&
          BASE_ADDR != ssp_pkg::BASE_SECOND) begin : bad_base
         $error("base address must be one of the two instance bases");
      end
   endgenerate

   // ****************************************************************
   // declarations
   // ****************************************************************
   localparam int CW = $clog2(ssp_pkg::FIFO_DEPTH) + 1;

   logic [15:0] ctrl0_q;
   logic [2:0] ctrl1_q;
   logic [7:0] presc_q;
   logic [3:0] mask_q;
   logic [1:0] latched_q;
   logic [6:0] idle_cnt_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   logic sck_oe_q;
   logic mosi_oe_q;

   ssp_pkg::serial_cfg_t cfg;
   logic setup;
   logic done;
   logic wr_done;
   logic rd_done;
   logic [11:0] offset;
   logic base_hit;
   logic mapped;
   logic [15:0] frame_mask;
   logic [15:0] tx_head;
   logic [15:0] rx_head;
   logic [15:0] rx_frame;
   logic tx_empty;
   logic tx_full;
   logic rx_empty;
   logic rx_full;
   logic [CW-1:0] tx_count;
   logic [CW-1:0] rx_count;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic busy;
   logic run_en;
   logic overrun_set;
   logic timeout_set;
   logic [3:0] raw;
   logic [3:0] masked;
   logic [4:0] status;
   logic [31:0] rd_word;
   logic [1:0] clr_bits;

   // ****************************************************************
   // decode helpers
   // ****************************************************************
   // one function serves both the access strobes and the error answer
   function automatic logic is_mapped(input logic [11:0] off);
      logic hit;
      hit = 1'b0;
      case (off)
         ssp_pkg::OFF_CTRL0, ssp_pkg::OFF_CTRL1, ssp_pkg::OFF_DATA,
         ssp_pkg::OFF_STAT, ssp_pkg::OFF_PRESC, ssp_pkg::OFF_MASK,
         ssp_pkg::OFF_RAW, ssp_pkg::OFF_MSKD, ssp_pkg::OFF_CLR: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : is_mapped

   function automatic logic is_reg(input logic [11:0] off,
                                   input logic [11:0] want);
      return off == want;
   endfunction : is_reg

   // ****************************************************************
   // apb transfer phases
   // ****************************************************************
   // the answer is taken at the first access edge, pready set in setup
   assign setup = psel && !penable;
   assign done = psel && penable && pready_q;
   assign offset = paddr[11:0];
   // both instances share the same offsets under their own base
   assign base_hit = (paddr[31:12] == BASE_ADDR[31:12]);
   assign mapped = base_hit && is_mapped(offset);
   assign wr_done = done && pwrite && mapped;
   assign rd_done = done && !pwrite && mapped;

   // ****************************************************************
   // data path between bus and fifos
   // ****************************************************************
   assign cfg = {presc_q, ctrl0_q};
   // a field value of n keeps n plus one low bits
   assign frame_mask = 16'hFFFF >> (4'hF - cfg.frame_size_select);
   // push on write, pop on read of the data port
   assign tx_push = wr_done && is_reg(offset, ssp_pkg::OFF_DATA);
   assign rx_pop = rd_done && is_reg(offset, ssp_pkg::OFF_DATA);
   // engine runs only when enabled as master
   assign run_en = ctrl1_q[ssp_pkg::C1_EN] && !ctrl1_q[ssp_pkg::C1_SLAVE];

   frame_fifo #(
      .WIDTH(ssp_pkg::FRAME_W),
      .DEPTH(ssp_pkg::FIFO_DEPTH)
   ) tx_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .push(tx_push),
      // upper bits beyond the frame are dropped on write
      .push_data(pwdata[15:0] & frame_mask),
      .pop(tx_pop),
      .pop_data(tx_head),
      .empty(tx_empty),
      .full(tx_full),
      .count(tx_count)
   );

   frame_fifo #(
      .WIDTH(ssp_pkg::FRAME_W),
      .DEPTH(ssp_pkg::FIFO_DEPTH)
   ) rx_fifo (
      .clk(pclk),
      .rst_n(presetn),
      .push(rx_push),
      .push_data(rx_frame),
      .pop(rx_pop),
      .pop_data(rx_head),
      .empty(rx_empty),
      .full(rx_full),
      .count(rx_count)
   );

   serial_engine engine (
      .clk(pclk),
      .rst_n(presetn),
      .run_en(run_en),
      .loop_back(ctrl1_q[ssp_pkg::C1_LOOP]),
      .cfg(cfg),
      .tx_avail(!tx_empty),
      .tx_data(tx_head),
      .tx_pop(tx_pop),
      .rx_push(rx_push),
      .rx_data(rx_frame),
      .busy(busy),
      .sck_q(sck_o),
      .mosi_q(mosi_o),
      .ssel_q(ssel_o),
      .miso(miso_i)
   );

   // ****************************************************************
   // status and interrupt sources
   // ****************************************************************
   // empty and not-full make 3 after reset
   assign status = {busy, rx_full, !rx_empty, !tx_full, tx_empty};
   // a frame arriving at a full receive fifo is lost and flagged
   assign overrun_set = rx_push && rx_full;
   assign timeout_set = !rx_empty &&
      (idle_cnt_q == 7'(ssp_pkg::TIMEOUT_CYC - 1));
   // transmit half-empty is live, so raw reads 8 out of reset
   assign raw = {
      (tx_count <= CW'(ssp_pkg::FIFO_DEPTH / 2)),
      (rx_count >= CW'(ssp_pkg::FIFO_DEPTH / 2)),
      latched_q
   };
   // masked view of the raw conditions
   assign masked = raw & mask_q;
   // writes of one to the clear register drop latched conditions
   assign clr_bits = (wr_done && is_reg(offset, ssp_pkg::OFF_CLR))
                     ? pwdata[1:0] : 2'h0;

   // ****************************************************************
   // read mux
   // ****************************************************************
   // unused upper bits read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (offset)
         ssp_pkg::OFF_CTRL0: rd_word[15:0] = ctrl0_q;
         ssp_pkg::OFF_CTRL1: rd_word[2:0] = ctrl1_q;
         ssp_pkg::OFF_DATA: rd_word[15:0] = rx_empty ? 16'h0000 : rx_head;
         ssp_pkg::OFF_STAT: rd_word[4:0] = status;
         ssp_pkg::OFF_PRESC: rd_word[7:0] = presc_q;
         ssp_pkg::OFF_MASK: rd_word[3:0] = mask_q;
         ssp_pkg::OFF_RAW: rd_word[3:0] = raw;
         ssp_pkg::OFF_MSKD: rd_word[3:0] = masked;
         default: rd_word = 32'h0000_0000;
      endcase
      if (!base_hit) rd_word = 32'h0000_0000;
   end

   // ****************************************************************
   // bus answer
   // ****************************************************************
   // answer is prepared in the setup cycle and held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         if (setup) prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      end
   end

   // ****************************************************************
   // software registers
   // ****************************************************************
   // control and mask registers reset to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl0_q <= ssp_pkg::CTRL0_RST;
         ctrl1_q <= ssp_pkg::CTRL1_RST;
         presc_q <= ssp_pkg::PRESC_RST;
         mask_q <= ssp_pkg::MASK_RST;
      end else if (wr_done) begin
         // sizes 0 to 2 are stored as written, software avoids them
         if (is_reg(offset, ssp_pkg::OFF_CTRL0)) ctrl0_q <= pwdata[15:0];
         // loop back, enable and slave select
         if (is_reg(offset, ssp_pkg::OFF_CTRL1)) ctrl1_q <= pwdata[2:0];
         // low bit stored as written, the engine ignores it so the divisor is always even
         if (is_reg(offset, ssp_pkg::OFF_PRESC)) presc_q <= pwdata[7:0];
         if (is_reg(offset, ssp_pkg::OFF_MASK)) mask_q <= pwdata[3:0];
      end
   end

   // ****************************************************************
   // latched interrupt conditions
   // ****************************************************************
   // set wins over a clear in the same cycle, so no event is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latched_q <= 2'h0;
         idle_cnt_q <= 7'h00;
      end else begin
         latched_q <= (latched_q & ~clr_bits) | {timeout_set, overrun_set};
         // idle time restarts on any receive fifo activity
         if (rx_push || rx_pop || rx_empty || timeout_set) idle_cnt_q <= 7'h00;
         else idle_cnt_q <= idle_cnt_q + 7'h01;
      end
   end

   // ****************************************************************
   // registered outputs
   // ****************************************************************
   // slave role is not driven here, so the pins are released then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
         sck_oe_q <= 1'b0;
         mosi_oe_q <= 1'b0;
      end else begin
         irq_q <= |masked;
         sck_oe_q <= run_en;
         mosi_oe_q <= run_en;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign sck_oe = sck_oe_q;
   assign mosi_oe = mosi_oe_q;
   assign ssel_oe = sck_oe_q;

endmodule : sync_serial_port_regs

// [tb_sync_serial_port_regs.sv]
// testbench: registers, interrupts and frames of the serial port
`timescale 1ns/1ps
module tb_sync_serial_port_regs;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r, v, m;
   logic pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe, e;
   logic ssel_o, ssel_oe, irq, miso;
   logic [4:0] nbits = 5'h08;
   logic [4:0] cnt;
   logic [15:0] got;
   logic [15:0] lfsr_q = 16'h003C;
   logic [15:0] rxq[$];
   logic [3:0] rv[9] = '{4'h0, 4'h0, 4'h0, 4'h3, 4'h0, 4'h0, 4'h8, 4'h0, 4'h0};
   logic [3:0] fs[3] = '{4'h3, 4'hB, 4'h7};
   int n_mismatch = 0;
   int compares = 0;
   localparam logic [31:0] B = ssp_pkg::BASE_FIRST;
   localparam logic [15:0] REPLY = 16'hC3A5;
   always #5 pclk = ~pclk;
   sync_serial_port_regs sync_serial_port_regs_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o),
      .mosi_oe(mosi_oe), .ssel_o(ssel_o), .ssel_oe(ssel_oe), .miso_i(miso),
      .irq(irq));
   ssp_peer #(.REPLY(REPLY)) ssp_peer_i (.sck(sck_o), .mosi(mosi_o),
      .ssel(ssel_o), .miso(miso), .nbits(nbits), .got(got), .cnt(cnt));
   task automatic cmp(input string nm, input logic [31:0] s, x);
      compares++;
      if (s !== x) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, x, s);
      end
   endtask : cmp
   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[14:0], ^(lfsr_q & 16'hB400)};
      return {16'h0, lfsr_q};
   endfunction : rnd
   // one apb transfer, held until pready is seen
   task automatic apb(input logic w, input logic [31:0] a, d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [11:0] o, input logic [31:0] x, string nm);
      apb(1'b0, B + {20'h0, o}, 32'h0);
      cmp(nm, r, x);
   endtask : rd
   // engine start is a few cycles late, so settle before polling
   task automatic idle();
      repeat (4) @(posedge pclk);
      for (int k = 0; k < 100; k++) begin
         apb(1'b0, B + 32'hC, 32'h0);
         if (r[0] === 1'b1 && r[4] === 1'b0) break;
      end
   endtask : idle
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rv[i]) rd(12'(4 * i), {28'h0, rv[i]}, "reset");
      cmp("oe", {29'h0, sck_oe, mosi_oe, ssel_oe}, 32'h0);
      // random writes keep legal size and format
      repeat (4) begin
         v = rnd();
         if (v[3:0] < 4'h3) v[3:0] = 4'h3;
         if (v[5:4] == 2'h3) v[5:4] = 2'h0;
         // data port skipped so no stale frame waits in the fifo
         for (int i = 0; i < 6; i++) if (i != 2) apb(1'b1, B + 32'(4 * i), v);
         rd(12'h000, v, "ctrl0");
         rd(12'h004, v & 32'h7, "ctrl1");
         rd(12'h010, v & 32'hFF, "presc");
         rd(12'h014, v & 32'hF, "mask");
         apb(1'b1, B + 32'h18, v);
         rd(12'h018, 32'h8, "raw");
      end
      apb(1'b1, B + 32'h14, 32'h8);
      rd(12'h01C, 32'h8, "masked");
      cmp("irq", {31'h0, irq}, 32'h1);
      apb(1'b1, B + 32'h14, 32'h0);
      rd(12'h01C, 32'h0, "masked");
      cmp("irq", {31'h0, irq}, 32'h0);
      apb(1'b0, B + 32'h24, 32'h0);
      cmp("err", {31'h0, e}, 32'h1);
      apb(1'b1, ssp_pkg::BASE_SECOND, 32'h0);
      cmp("err", {31'h0, e}, 32'h1);
      // frame lengths 4, 12 and 8 in both directions
      apb(1'b1, B + 32'h4, 32'h2);
      apb(1'b1, B + 32'h10, 32'h2);
      cmp("oe", {29'h0, sck_oe, mosi_oe, ssel_oe}, 32'h7);
      foreach (fs[i]) begin
         nbits <= {1'b0, fs[i]} + 5'h01;
         m = (32'h1 << (fs[i] + 1)) - 32'h1;
         apb(1'b1, B, {28'h0, fs[i]});
         v = rnd();
         apb(1'b1, B + 32'h8, v);
         rxq.push_back(REPLY & m[15:0]);
         idle();
         cmp("sent", {16'h0, got}, v & m);
         cmp("bits", {27'h0, cnt}, {27'h0, nbits});
         rd(12'h008, {16'h0, rxq.pop_front()}, "rx");
      end
      rd(12'h008, 32'h0, "empty");
      // loop back returns the sent frame itself
      apb(1'b1, B + 32'h4, 32'h3);
      // ninth frame overruns the full receive side
      repeat (9) begin
         v = rnd();
         apb(1'b1, B + 32'h8, v);
         if (rxq.size() < 8) rxq.push_back(v[15:0] & 16'hFF);
         idle();
      end
      // timeout latches once the full receive side sits idle
      repeat (70) @(posedge pclk);
      apb(1'b0, B + 32'h18, 32'h0);
      cmp("raw", r & 32'hF, 32'hF);
      apb(1'b1, B + 32'h20, 32'h3);
      apb(1'b0, B + 32'h18, 32'h0);
      cmp("raw", r & 32'h3, 32'h0);
      while (rxq.size() > 0) rd(12'h8, {16'h0, rxq.pop_front()}, "rx");
      rd(12'h00C, 32'h3, "status");
      close_out();
   end
endmodule : tb_sync_serial_port_regs
